// [logic/range_coding_pkg.sv]
// constants and types shared by the result range coding block
package range_coding_pkg;

   // =====================================================================
   // register map, byte offsets on the wishbone slave
   localparam logic [7:0] CTRL_OFS     = 8'h00;
   localparam logic [7:0] DATA_OFS     = 8'h04;
   localparam logic [7:0] CHSTAT_OFS   = 8'h08;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h0C;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h10;

   // =====================================================================
   // control field positions
   localparam int CTRL_SAT_BIT   = 0;
   localparam int CTRL_CHOP_BIT  = 1;
   localparam int CTRL_BIP_BIT   = 2;
   localparam int CTRL_CONT_BIT  = 3;
   localparam int CTRL_START_BIT = 4;

   // channel status field positions
   localparam int CHST_SIGN_BIT = 0;
   localparam int CHST_OVR_BIT  = 1;
   localparam int CHST_BUSY_BIT = 2;

   // interrupt status field positions
   localparam int IRQ_RDY_BIT = 0;
   localparam int IRQ_OVR_BIT = 1;
   localparam int IRQ_W       = 2;

   // =====================================================================
   // reset values
   localparam logic [3:0]  CTRL_RST  = 4'h0;
   localparam logic [15:0] DATA_RST  = 16'h0000;
   localparam logic [1:0]  IRQ_RST   = 2'h0;

   // =====================================================================
   // timing in master clock cycles
   localparam logic [7:0] SETTLE_FIRST_CYC = 8'd43;
   localparam logic [7:0] SETTLE_CHOP_CYC  = 8'd42;
   localparam logic [7:0] SCALE_CYC        = 8'd163;

   // =====================================================================
   // code limits
   localparam logic [15:0] CODE_ALL_ONES  = 16'hFFFF;
   localparam logic [15:0] CODE_ALL_ZEROS = 16'h0000;

   // widths
   localparam int RAW_W  = 18;
   localparam int CODE_W = 16;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_SETTLE1 = 3'b001,
      ST_SAMPLE1 = 3'b010,
      ST_SETTLE2 = 3'b011,
      ST_SAMPLE2 = 3'b100,
      ST_SCALE   = 3'b101
   } conv_state_t;

endpackage

// [logic/adc_result_range_coding.sv]
// conversion sequencer, chopped averaging and range coding of one result
//
// Functional notes
// - saturate enabled and result out of nominal range: store all zeros or ones.
// - saturate disabled: store unclamped wrapped result except unipolar below (0000), sign and overrange tell truth.
// - overrange flag comes only from the digital result, never from pin voltage.
// - unipolar: 0000-FFFF normal; above wraps with overrange; below reads 0000, sign set.
// - bipolar: 8000-FFFF sign 0, 0000-7FFF sign 1; beyond either end wraps, overrange.
// - chopping alternates polarity; output averages normal then reversed conversion.
// - chop cycle: settle, sample, settle 42, reversed sample, 163 scaling cycles.
`timescale 1ns/100ps
module adc_result_range_coding (
   input  wire logic                                      clk_i,
   input  wire logic                                      rst_i,
   input  wire logic                                      wb_cyc_i,
   input  wire logic                                      wb_stb_i,
   input  wire logic                                      wb_we_i,
   input  wire logic [7:0]                                wb_adr_i,
   input  wire logic [3:0]                                wb_sel_i,
   input  wire logic [31:0]                               wb_dat_i,
   output logic      [31:0]                               wb_dat_o,
   output logic                                           wb_ack_o,
   input  wire logic signed [range_coding_pkg::RAW_W-1:0] filter_data_i,
   input  wire logic                                      filter_valid_i,
   output logic                                           sample_en_o,
   output logic                                           chop_reverse_o,
   output logic                                           irq_o
);

   // =====================================================================
   // wishbone decode
   logic [3:0]  ctrl_q;
   logic [15:0] data_q;
   logic        sign_q;
   logic        ovr_q;
   logic [1:0]  irq_stat_q;
   logic [1:0]  irq_mask_q;
   logic        busy;

   wire req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr      = req & wb_we_i & wb_sel_i[0];
   wire hit_ctl = wb_adr_i == range_coding_pkg::CTRL_OFS;
   wire hit_dat = wb_adr_i == range_coding_pkg::DATA_OFS;
   wire hit_chs = wb_adr_i == range_coding_pkg::CHSTAT_OFS;
   wire hit_ist = wb_adr_i == range_coding_pkg::IRQ_STAT_OFS;
   wire hit_msk = wb_adr_i == range_coding_pkg::IRQ_MASK_OFS;
   wire start   = wr & hit_ctl & wb_dat_i[range_coding_pkg::CTRL_START_BIT];

   wire sat_en  = ctrl_q[range_coding_pkg::CTRL_SAT_BIT];
   wire chop_en = ctrl_q[range_coding_pkg::CTRL_CHOP_BIT];
   wire bipolar = ctrl_q[range_coding_pkg::CTRL_BIP_BIT];
   wire cont    = ctrl_q[range_coding_pkg::CTRL_CONT_BIT];

   wire [31:0] rd_mux =
      hit_ctl ? {28'h000_0000, ctrl_q} :
      hit_dat ? {16'h0000, data_q} :
      hit_chs ? {29'h000_0000, busy, ovr_q, sign_q} :
      hit_ist ? {30'h000_0000, irq_stat_q} :
      hit_msk ? {30'h000_0000, irq_mask_q} : 32'h0000_0000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= req ? rd_mux : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q     <= range_coding_pkg::CTRL_RST;
         irq_mask_q <= range_coding_pkg::IRQ_RST;
      end else begin
         if (wr & hit_ctl)
            ctrl_q <= wb_dat_i[3:0];
         if (wr & hit_msk)
            irq_mask_q <= wb_dat_i[1:0];
      end
   end

   // =====================================================================
   // conversion sequencer
   range_coding_pkg::conv_state_t state_q, state_d;
   logic [7:0]                        cnt_q, cnt_d;
   logic signed [range_coding_pkg::RAW_W-1:0] first_q;
   logic signed [range_coding_pkg::RAW_W-1:0] result_q;
   logic                                      done;

   assign busy = state_q != range_coding_pkg::ST_IDLE;

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      done    = 1'b0;
      case (state_q)
         range_coding_pkg::ST_IDLE: begin
            if (start) begin
               state_d = range_coding_pkg::ST_SETTLE1;
               cnt_d   = range_coding_pkg::SETTLE_FIRST_CYC;
            end
         end
         range_coding_pkg::ST_SETTLE1: begin
            cnt_d = cnt_q - 8'd1;
            if (cnt_q == 8'd1)
               state_d = range_coding_pkg::ST_SAMPLE1;
         end
         range_coding_pkg::ST_SAMPLE1: begin
            if (filter_valid_i) begin
               if (chop_en) begin
                  state_d = range_coding_pkg::ST_SETTLE2;
                  cnt_d   = range_coding_pkg::SETTLE_CHOP_CYC;
               end else begin
                  state_d = range_coding_pkg::ST_SCALE;
                  cnt_d   = range_coding_pkg::SCALE_CYC;
               end
            end
         end
         range_coding_pkg::ST_SETTLE2: begin
            cnt_d = cnt_q - 8'd1;
            if (cnt_q == 8'd1)
               state_d = range_coding_pkg::ST_SAMPLE2;
         end
         range_coding_pkg::ST_SAMPLE2: begin
            if (filter_valid_i) begin
               state_d = range_coding_pkg::ST_SCALE;
               cnt_d   = range_coding_pkg::SCALE_CYC;
            end
         end
         range_coding_pkg::ST_SCALE: begin
            cnt_d = cnt_q - 8'd1;
            if (cnt_q == 8'd1) begin
               done    = 1'b1;
               cnt_d   = range_coding_pkg::SETTLE_FIRST_CYC;
               state_d = cont ? range_coding_pkg::ST_SETTLE1 : range_coding_pkg::ST_IDLE;
            end
         end
         default: begin
            state_d = range_coding_pkg::ST_IDLE;
            cnt_d   = 8'd0;
         end
      endcase
   end

   // chopped average: sum one bit wider so the halving cannot overflow
   wire signed [range_coding_pkg::RAW_W:0] chop_sum = first_q + filter_data_i;
   wire signed [range_coding_pkg::RAW_W-1:0] chop_avg =
      chop_sum[range_coding_pkg::RAW_W:1];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q        <= range_coding_pkg::ST_IDLE;
         cnt_q          <= 8'd0;
         first_q        <= '0;
         result_q       <= '0;
         sample_en_o    <= 1'b0;
         chop_reverse_o <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         if (state_q == range_coding_pkg::ST_SAMPLE1 && filter_valid_i) begin
            first_q  <= filter_data_i;
            result_q <= filter_data_i;
         end
         if (state_q == range_coding_pkg::ST_SAMPLE2 && filter_valid_i)
            result_q <= chop_avg;
         sample_en_o <= state_d == range_coding_pkg::ST_SAMPLE1 ||
                        state_d == range_coding_pkg::ST_SAMPLE2;
         // inputs reversed from the second settle through the second sample
         chop_reverse_o <= state_d == range_coding_pkg::ST_SETTLE2 ||
                           state_d == range_coding_pkg::ST_SAMPLE2;
      end
   end

   // =====================================================================
   // range coding; result is an offset code, nominal 0000..FFFF in both ranges
   wire above = ~result_q[range_coding_pkg::RAW_W-1] &
                (|result_q[range_coding_pkg::RAW_W-2:range_coding_pkg::CODE_W]);
   wire below = result_q[range_coding_pkg::RAW_W-1];
   wire [15:0] wrapped = result_q[range_coding_pkg::CODE_W-1:0];

   // overrange is purely a comparison on the digital result
   wire ovr_d = above | below;

   wire sign_d = below | (bipolar & ~above & ~wrapped[15]);

   wire [15:0] code_d =
      (sat_en & above)    ? range_coding_pkg::CODE_ALL_ONES :
      (sat_en & below)    ? range_coding_pkg::CODE_ALL_ZEROS :
      (~bipolar & below)  ? range_coding_pkg::CODE_ALL_ZEROS :
                            wrapped;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data_q <= range_coding_pkg::DATA_RST;
         sign_q <= 1'b0;
         ovr_q  <= 1'b0;
      end else if (done) begin
         data_q <= code_d;
         sign_q <= sign_d;
         ovr_q  <= ovr_d;
      end
   end

   // =====================================================================
   // interrupts: write one to clear, a same-cycle event wins
   wire [1:0] irq_set = {done & ovr_d, done};
   wire [1:0] irq_clr = (wr & hit_ist) ? wb_dat_i[1:0] : 2'b00;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_q <= range_coding_pkg::IRQ_RST;
         irq_o      <= 1'b0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
         irq_o      <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_mask_q);
      end
   end

endmodule

// [tb/range_coding_monitor.sv]
// port assertions for the result range coding block
`timescale 1ns/100ps
module range_coding_monitor (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        filter_valid_i,
   input wire logic        sample_en_o,
   input wire logic        chop_reverse_o,
   input wire logic        irq_o
);
   // ======================================================================
   // bus answer and conversion timing
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire req = wb_cyc_i & wb_stb_i;
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_answers: assert property (req && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered in the next cycle");
   a_ack_cause: assert property (wb_ack_o |-> $past(req))
      else $error("ack without a request");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data not zero outside ack");
   a_rev_quiet: assert property ($rose(chop_reverse_o) |-> !sample_en_o [*8])
      else $error("reversed sample started without settling");
   a_rev_sample: assert property ($rose(chop_reverse_o) |->
      ##[40:44] (sample_en_o && chop_reverse_o))
      else $error("reversed sample not started after settling");
   a_sample_close: assert property (filter_valid_i && sample_en_o |-> ##[1:2] !sample_en_o)
      else $error("sampling phase not closed by a result");
   a_scale_quiet: assert property ($fell(sample_en_o) && !chop_reverse_o |=>
      !sample_en_o [*8])
      else $error("sampling resumed during scaling");
   c_write: cover property (wb_ack_o && wb_we_i);
   c_chop: cover property ($rose(chop_reverse_o));
   c_irq: cover property ($rose(irq_o));
endmodule

bind adc_result_range_coding range_coding_monitor range_coding_monitor_inst (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .filter_valid_i(filter_valid_i), .sample_en_o(sample_en_o),
   .chop_reverse_o(chop_reverse_o), .irq_o(irq_o));

// [tb/test_adc_result_range_coding.sv]
// self-checking bench for the result range coding block
`timescale 1ns/100ps
module test_adc_result_range_coding;
   logic               clk_i = 1'b0;
   logic               rst_i = 1'b1;
   logic               cyc = 1'b0;
   logic               stb = 1'b0;
   logic               we = 1'b0;
   logic               valid = 1'b0;
   logic               rev;
   logic [7:0]         adr = 8'h00;
   logic [3:0]         sel = 4'hF;
   logic [31:0]        dat = 32'h0000_0000;
   logic [31:0]        q;
   logic [31:0]        wb_dat_o;
   logic signed [17:0] fdat = 18'sh0_0000;
   logic               wb_ack_o;
   logic               sample_en_o;
   logic               chop_reverse_o;
   logic               irq_o;
   int                 err_count = 0;
   int                 checks = 0;
   int                 cycles = 0;
   // result table: control, first sample, stored code, {overrange, sign}
   logic [3:0]         tc [10] = '{4'h0, 4'h0, 4'h0, 4'h4, 4'h4, 4'h4, 4'h4, 4'h1, 4'h5, 4'h2};
   logic signed [17:0] ta [10] = '{18'sh1_0001, -18'sh1, 18'sh0_FFFF, 18'sh0_8000,
      18'sh0_7FFF, -18'sh2, 18'sh1_0000, 18'sh1_0001, -18'sh2, 18'sh0_1000};
   logic [15:0]        td [10] = '{16'h0001, 16'h0000, 16'hFFFF, 16'h8000, 16'h7FFF,
      16'hFFFE, 16'h0000, 16'hFFFF, 16'h0000, 16'h1800};
   logic [1:0]         ts [10] = '{2'h2, 2'h3, 2'h0, 2'h0, 2'h1, 2'h3, 2'h2, 2'h2, 2'h3, 2'h0};
   always #2.5 clk_i = ~clk_i;
   adc_result_range_coding adc_result_range_coding_inst (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .filter_data_i(fdat), .filter_valid_i(valid),
      .sample_en_o(sample_en_o), .chop_reverse_o(chop_reverse_o), .irq_o(irq_o));
   // ======================================================================
   // tasks
   task automatic stop_test;
      if (err_count == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0000_0000);
      chk(q, e);
   endtask
   task automatic feed(input logic signed [17:0] v);
      do @(posedge clk_i); while (sample_en_o !== 1'b1);
      rev = chop_reverse_o;
      fdat <= v;
      valid <= 1'b1;
      @(posedge clk_i);
      valid <= 1'b0;
   endtask
   task automatic conv(input int i);
      int n;
      n = 0;
      wb(1'b1, range_coding_pkg::CTRL_OFS, {27'h0, 1'b1, tc[i]});
      feed(ta[i]);
      chk({31'h0, rev}, 32'h0000_0000);
      if (tc[i][range_coding_pkg::CTRL_CHOP_BIT]) begin
         feed(18'sh0_2001);
         chk({31'h0, rev}, 32'h0000_0001);
      end
      do begin
         @(posedge clk_i);
         n++;
      end while (irq_o !== 1'b1);
      chk({31'h0, n >= 163 && n <= 170}, 32'h0000_0001);
      rd(range_coding_pkg::DATA_OFS, {16'h0, td[i]});
      rd(range_coding_pkg::CHSTAT_OFS, {30'h0, ts[i]});
      rd(range_coding_pkg::IRQ_STAT_OFS, {30'h0, ts[i][1], 1'b1});
      rd(range_coding_pkg::CTRL_OFS, {28'h0, tc[i]});
      wb(1'b1, range_coding_pkg::IRQ_MASK_OFS, 32'h0000_0000);
      @(posedge clk_i);
      chk({31'h0, irq_o}, 32'h0000_0000);
      wb(1'b1, range_coding_pkg::IRQ_MASK_OFS, 32'h0000_0003);
      @(posedge clk_i);
      chk({31'h0, irq_o}, 32'h0000_0001);
      wb(1'b1, range_coding_pkg::IRQ_STAT_OFS, 32'h0000_0003);
      @(posedge clk_i);
      chk({31'h0, irq_o}, 32'h0000_0000);
   endtask
   // hang guard, about ten times the expected run
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         err_count++;
         stop_test;
      end
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(range_coding_pkg::CTRL_OFS, 32'h0000_0000);
      rd(range_coding_pkg::DATA_OFS, 32'h0000_0000);
      rd(range_coding_pkg::IRQ_STAT_OFS, 32'h0000_0000);
      rd(8'h20, 32'h0000_0000);
      wb(1'b1, range_coding_pkg::IRQ_MASK_OFS, 32'h0000_0003);
      rd(range_coding_pkg::IRQ_MASK_OFS, 32'h0000_0003);
      // a write without the low byte lane must leave the register alone
      sel <= 4'hE;
      wb(1'b1, range_coding_pkg::IRQ_MASK_OFS, 32'h0000_0000);
      sel <= 4'hF;
      rd(range_coding_pkg::IRQ_MASK_OFS, 32'h0000_0003);
      for (int i = 0; i < 10; i++) begin
         conv(i);
      end
      // continuous mode restarts by itself; clearing the bit ends it after the next result
      wb(1'b1, range_coding_pkg::CTRL_OFS, 32'h0000_0018);
      feed(18'sh0_1234);
      do @(posedge clk_i); while (irq_o !== 1'b1);
      rd(range_coding_pkg::DATA_OFS, 32'h0000_1234);
      rd(range_coding_pkg::CHSTAT_OFS, 32'h0000_0004);
      wb(1'b1, range_coding_pkg::CTRL_OFS, 32'h0000_0000);
      wb(1'b1, range_coding_pkg::IRQ_STAT_OFS, 32'h0000_0003);
      feed(18'sh0_0042);
      do @(posedge clk_i); while (irq_o !== 1'b1);
      rd(range_coding_pkg::DATA_OFS, 32'h0000_0042);
      rd(range_coding_pkg::CHSTAT_OFS, 32'h0000_0000);
      stop_test;
   end
endmodule
